// >>> src/lcd_timing_consts.vh
// Constants for the LCD panel timing, power and contrast block
`ifndef LCD_TIMING_CONSTS_VH
`define LCD_TIMING_CONSTS_VH

// APB byte offsets
`define OFS_FIRST_CTRL    12'h000
`define OFS_SECOND_CTRL   12'h004
`define OFS_VERT_TIMING   12'h008
`define OFS_HORIZ_TIMING  12'h00C
`define OFS_FRAME_SIZE    12'h010
`define OFS_PANEL_POWER   12'h014
`define OFS_CONTRAST_CTRL 12'h018
`define OFS_CONTRAST_CMP  12'h01C

// First control: divider [8:0], skip bit 12, line counter [31:21]
`define FC_DIV_LSB     0
`define FC_DIV_MSB     8
`define FC_SKIP_BIT    12
`define FC_LCNT_LSB    21
// Second control: panel type [1:0], clock mode bit 15, polarities [12:8]
`define SC_TYPE_LSB    0
`define SC_TYPE_MSB    1
`define SC_CLKMODE_BIT 15
`define SC_POL_LSB     8
`define SC_POL_MSB     12
`define PT_TFT         2'h2
// Polarity bit positions inside the 5-bit polarity field
`define POL_DATA_BIT   0
`define POL_LINE_BIT   1
`define POL_FRAME_BIT  2
`define POL_VALID_BIT  3
`define POL_CLK_BIT    4
// Vertical timing: frame back porch [7:0], frame sync width [13:8],
// start-to-sync delay [31:24]
`define VT_FBP_LSB     0
`define VT_FSW_LSB     8
`define VT_DLY_LSB     24
// Horizontal timing: back porch [7:0], sync width [13:8], front porch [31:21]
`define HT_BP_LSB      0
`define HT_SW_LSB      8
`define HT_FP_LSB      21
// Horizontal timing also carries the frame front porch in [20:16]
`define HT_FFP_LSB     16
// Frame size: vertical size [10:0], horizontal size [31:21]
`define FS_V_LSB       0
`define FS_H_LSB       21
// Panel power: enable bit 0, guard frames [7:1]
`define PP_EN_BIT      0
`define PP_GUARD_LSB   1
`define PP_GUARD_MSB   7
`define PP_RESET       32'h0000000E
// Contrast control: prescale [1:0], level select bit 2, enable bit 3
`define CC_PS_LSB      0
`define CC_PS_MSB      1
`define CC_LEVEL_BIT   2
`define CC_EN_BIT      3
`define CC_RESET       32'h00000000
`define CMP_RESET      32'h00000000

`endif

// >>> src/lcd_panel_timing.v
// LCD panel timing generator with power sequencing and contrast PWM
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "lcd_timing_consts.vh"

module lcd_panel_timing #(
    parameter DATA_W = 24
) (
    input  wire              i_ref_clk,
    input  wire              i_rst,
    input  wire              i_psel,
    input  wire              i_penable,
    input  wire              i_pwrite,
    input  wire [11:0]       i_paddr,
    input  wire [31:0]       i_pwdata,
    input  wire [DATA_W-1:0] i_pixel_data,
    output reg  [31:0]       o_prdata,
    output reg               o_pready,
    output reg               o_pslverr,
    output reg               o_pixel_clock_out,
    output reg               o_data_valid_out,
    output reg               o_line_sync_out,
    output reg               o_frame_sync_out,
    output reg  [DATA_W-1:0] o_pixel_data_bus,
    output reg               o_panel_power,
    output reg               o_contrast_out
);

    // Phase states of one line
    localparam [4:0] PH_DLY  = 5'h01;
    localparam [4:0] PH_SYNC = 5'h02;
    localparam [4:0] PH_BP   = 5'h04;
    localparam [4:0] PH_ACT  = 5'h08;
    localparam [4:0] PH_FP   = 5'h10;

    reg  [31:0] first_ctrl;
    reg  [31:0] second_ctrl;
    reg  [31:0] vert_timing;
    reg  [31:0] horiz_timing;
    reg  [31:0] frame_size;
    reg  [31:0] panel_power;
    reg  [31:0] contrast_ctrl;
    reg  [31:0] contrast_cmp;
    reg  [10:0] line_counter;
    reg  [31:0] next_rdata;
    reg         addr_ok;

    wire        access     = i_psel & i_penable & o_pready;
    wire        wr         = access & i_pwrite;
    wire [8:0]  div        = first_ctrl[`FC_DIV_MSB:`FC_DIV_LSB];
    wire        skip       = first_ctrl[`FC_SKIP_BIT];
    wire        is_tft     = (second_ctrl[`SC_TYPE_MSB:`SC_TYPE_LSB] == `PT_TFT);
    wire        clk_cont   = second_ctrl[`SC_CLKMODE_BIT];
    wire [4:0]  contrast_level_select        = second_ctrl[`SC_POL_MSB:`SC_POL_LSB];
    wire [7:0]  st_dly     = vert_timing[`VT_DLY_LSB +: 8];
    wire [5:0]  fsw        = vert_timing[`VT_FSW_LSB +: 6];
    wire [7:0]  fbp        = vert_timing[`VT_FBP_LSB +: 8];
    wire [7:0]  line_back_porch        = horiz_timing[`HT_BP_LSB +: 8];
    wire [5:0]  hsw        = horiz_timing[`HT_SW_LSB +: 6];
    wire [10:0] line_front_porch        = horiz_timing[`HT_FP_LSB +: 11];
    wire [4:0]  ffp        = horiz_timing[`HT_FFP_LSB +: 5];
    wire [10:0] vsize      = frame_size[`FS_V_LSB +: 11];
    wire [10:0] hsize      = frame_size[`FS_H_LSB +: 11];

    // APB decode; every register answers in the access cycle, no wait states
    always @* begin
        addr_ok    = 1'b1;
        next_rdata = 32'h00000000;
        case (i_paddr)
            `OFS_FIRST_CTRL:    next_rdata = {line_counter, first_ctrl[20:0]};
            `OFS_SECOND_CTRL:   next_rdata = second_ctrl;
            `OFS_VERT_TIMING:   next_rdata = vert_timing;
            `OFS_HORIZ_TIMING:  next_rdata = horiz_timing;
            `OFS_FRAME_SIZE:    next_rdata = frame_size;
            `OFS_PANEL_POWER:   next_rdata = panel_power;
            `OFS_CONTRAST_CTRL: next_rdata = contrast_ctrl;
            `OFS_CONTRAST_CMP:  next_rdata = contrast_cmp;
            default:            addr_ok = 1'b0;
        endcase
    end

    // Ready is registered from setup so the access phase completes at its first edge
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_pready      <= 1'b0;
            o_prdata      <= 32'h00000000;
            o_pslverr     <= 1'b0;
            first_ctrl    <= 32'h00000000;
            second_ctrl   <= 32'h00000000;
            vert_timing   <= 32'h00000000;
            horiz_timing  <= 32'h00000000;
            frame_size    <= 32'h00000000;
            panel_power   <= `PP_RESET;
            contrast_ctrl <= `CC_RESET;
            contrast_cmp  <= `CMP_RESET;
        end else begin
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~addr_ok;
            if (i_psel & ~i_penable) begin
                o_prdata <= i_pwrite ? 32'h00000000 : next_rdata;
            end
            if (wr & addr_ok) begin
                case (i_paddr)
                    `OFS_FIRST_CTRL:    first_ctrl    <= {11'h000, i_pwdata[20:0]};
                    `OFS_SECOND_CTRL:   second_ctrl   <= i_pwdata;
                    `OFS_VERT_TIMING:   vert_timing   <= i_pwdata;
                    `OFS_HORIZ_TIMING:  horiz_timing  <= i_pwdata;
                    `OFS_FRAME_SIZE:    frame_size    <= i_pwdata;
                    `OFS_PANEL_POWER:   panel_power   <= {24'h000000, i_pwdata[7:0]};
                    `OFS_CONTRAST_CTRL: contrast_ctrl <= i_pwdata;
                    `OFS_CONTRAST_CMP:  contrast_cmp  <= {24'h000000, i_pwdata[7:0]};
                    default:            first_ctrl    <= first_ctrl;
                endcase
            end
        end
    end

    // Pixel clock divider: one tick per pixel period, half-period toggles.
    // Divider 0 is treated like 1 so the clock never stops.
    reg  [8:0] div_cnt;
    reg        pclk_int;
    reg        tick;
    wire [8:0] div_eff = (div == 9'h000) ? 9'h001 : div;
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            div_cnt  <= 9'h000;
            pclk_int <= 1'b0;
            tick     <= 1'b0;
        end else if (skip) begin
            div_cnt  <= 9'h000;
            pclk_int <= ~pclk_int;
            tick     <= 1'b1;
        end else if (div_cnt == div_eff - 9'h001) begin
            div_cnt  <= 9'h000;
            pclk_int <= ~pclk_int;
            tick     <= pclk_int; // Period is twice the divider
        end else begin
            div_cnt  <= div_cnt + 9'h001;
            tick     <= 1'b0;
        end
    end

    // Line and frame sequencer, advanced once per pixel period
    reg [4:0]  phase;
    reg [10:0] ph_cnt;
    reg [11:0] line_idx;
    wire [11:0] frame_lines = {4'h0, fbp} + {1'b0, vsize} + {7'h00, ffp} + 12'h001;
    wire        line_end    = (phase == PH_FP) && (ph_cnt == line_front_porch + 11'h001);
    wire [11:0] act_first   = {4'h0, fbp};
    wire        line_active = (line_idx >= act_first) &&
                              (line_idx <= act_first + {1'b0, vsize});
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            phase    <= PH_DLY;
            ph_cnt   <= 11'h000;
            line_idx <= 12'h000;
        end else if (tick & o_panel_power) begin
            ph_cnt <= ph_cnt + 11'h001;
            case (phase)
                PH_DLY: if (ph_cnt == {3'h0, st_dly}) begin
                    phase  <= PH_SYNC;
                    ph_cnt <= 11'h000;
                end
                PH_SYNC: if (ph_cnt == {5'h00, hsw}) begin
                    phase  <= PH_BP;
                    ph_cnt <= 11'h000;
                end
                PH_BP: if (ph_cnt == {3'h0, line_back_porch}) begin
                    phase  <= PH_ACT;
                    ph_cnt <= 11'h000;
                end
                PH_ACT: if (ph_cnt == hsize) begin
                    phase  <= PH_FP;
                    ph_cnt <= 11'h000;
                end
                PH_FP: if (line_end) begin
                    phase    <= PH_DLY;
                    ph_cnt   <= 11'h000;
                    line_idx <= (line_idx + 12'h001 >= frame_lines) ? 12'h000
                                : line_idx + 12'h001;
                end
                default: begin
                    phase  <= PH_DLY;
                    ph_cnt <= 11'h000;
                end
            endcase
        end else if (~o_panel_power) begin
            phase    <= PH_DLY;
            ph_cnt   <= 11'h000;
            line_idx <= 12'h000;
        end
    end

    // Output stage; each output flopped, polarity applied last
    wire act_now  = (phase == PH_ACT) && line_active && o_panel_power;
    wire fs_raw   = is_tft ? (line_idx <= {6'h00, fsw})
                           : (line_idx == 12'h000);
    wire clk_run  = clk_cont | act_now;
    reg  hs_prev;
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_pixel_clock_out <= 1'b0;
            o_data_valid_out  <= 1'b0;
            o_line_sync_out   <= 1'b0;
            o_frame_sync_out  <= 1'b0;
            o_pixel_data_bus  <= {DATA_W{1'b0}};
            hs_prev           <= 1'b0;
            line_counter      <= 11'h000;
        end else begin
            o_pixel_clock_out <= (pclk_int & clk_run & o_panel_power) ^ contrast_level_select[`POL_CLK_BIT];
            o_data_valid_out  <= act_now ^ contrast_level_select[`POL_VALID_BIT];
            o_line_sync_out   <= ((phase == PH_SYNC) & o_panel_power)
                                 ^ contrast_level_select[`POL_LINE_BIT];
            o_frame_sync_out  <= (fs_raw & o_panel_power) ^ contrast_level_select[`POL_FRAME_BIT];
            o_pixel_data_bus  <= act_now ? (i_pixel_data ^ {DATA_W{contrast_level_select[`POL_DATA_BIT]}})
                                         : {DATA_W{contrast_level_select[`POL_DATA_BIT]}};
            hs_prev           <= (phase == PH_SYNC);
            // Reload at frame start so the count runs down through the frame
            if (line_end && line_idx + 12'h001 >= frame_lines) begin
                line_counter <= vsize;
            end else if (hs_prev && phase != PH_SYNC) begin
                line_counter <= line_counter - 11'h001;
            end
        end
    end

    // Power sequencing: count guard frames after each write of the power bit.
    // A guard of zero still waits one frame; software must not rely on it.
    reg        pwr_pend;
    reg [6:0]  guard_cnt;
    reg [15:0] frame_tick_div;
    wire       pwr_wr   = wr && (i_paddr == `OFS_PANEL_POWER);
    wire       frm_tick = o_panel_power ? (line_end & tick & (line_idx + 12'h001 >= frame_lines))
                                        : (tick && frame_tick_div == 16'h0000);
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            pwr_pend       <= 1'b0;
            guard_cnt      <= 7'h00;
            o_panel_power  <= 1'b0;
            frame_tick_div <= 16'h0000;
        end else begin
            // While powered down frames are estimated from a fixed pixel count
            if (tick) begin
                frame_tick_div <= frame_tick_div + 16'h0001;
            end
            if (pwr_wr) begin
                pwr_pend  <= 1'b1;
                guard_cnt <= i_pwdata[`PP_GUARD_MSB:`PP_GUARD_LSB];
            end else if (pwr_pend && frm_tick) begin
                if (guard_cnt <= 7'h01) begin
                    pwr_pend      <= 1'b0;
                    o_panel_power <= panel_power[`PP_EN_BIT];
                end else begin
                    guard_cnt <= guard_cnt - 7'h01;
                end
            end
        end
    end

    // Contrast PWM with four prescale rates
    reg  [7:0] pre_cnt;
    reg  [7:0] pwm_cnt;
    reg        pre_hit;
    wire [1:0] ps = contrast_ctrl[`CC_PS_MSB:`CC_PS_LSB];
    always @* begin
        case (ps)
            2'h0:    pre_hit = 1'b1;
            2'h1:    pre_hit = (pre_cnt[0] == 1'b1);
            2'h2:    pre_hit = (pre_cnt[1:0] == 2'h3);
            default: pre_hit = (pre_cnt[2:0] == 3'h7);
        endcase
    end
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            pre_cnt        <= 8'h00;
            pwm_cnt        <= 8'h00;
            o_contrast_out <= 1'b0;
        end else begin
            pre_cnt <= pre_cnt + 8'h01;
            if (pre_hit) begin
                pwm_cnt <= pwm_cnt + 8'h01; // 256-step period
            end
            if (~contrast_ctrl[`CC_EN_BIT]) begin
                o_contrast_out <= 1'b0;
            end else if (pwm_cnt < contrast_cmp[7:0]) begin
                o_contrast_out <= contrast_ctrl[`CC_LEVEL_BIT];
            end else begin
                o_contrast_out <= ~contrast_ctrl[`CC_LEVEL_BIT];
            end
        end
    end

endmodule

// >>> bench/lcd_panel_timing_assertions.sv
// Port-level checks for the LCD panel timing block
`timescale 1ns/10ps
module lcd_panel_timing_assertions (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire o_pready,
    input wire o_pslverr,
    input wire o_data_valid_out,
    input wire o_line_sync_out,
    input wire o_frame_sync_out,
    input wire o_panel_power
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    // Outputs lag power by a cycle, so the past value is allowed
    chk_valid_powered: assert property (
        o_data_valid_out |-> o_panel_power || $past(o_panel_power))
        else $error("data valid while unpowered");
    chk_valid_sync_apart: assert property (
        o_data_valid_out |-> !o_line_sync_out)
        else $error("data valid during line sync");
    chk_back_porch_gap: assert property (
        $fell(o_line_sync_out) |-> !o_data_valid_out)
        else $error("no back porch after line sync");
    chk_front_porch_gap: assert property (
        $fell(o_data_valid_out) |-> !o_line_sync_out [*3])
        else $error("front porch and delay too short");
    chk_line_min_gap: assert property (
        $fell(o_line_sync_out) |-> !o_line_sync_out [*6])
        else $error("line shorter than its minimum");
    chk_frame_start_idle: assert property (
        $rose(o_frame_sync_out) |-> !o_data_valid_out && !o_line_sync_out)
        else $error("frame sync not at line start");
    chk_quiet_unpowered: assert property (
        !o_panel_power && !$past(o_panel_power) |->
            !o_line_sync_out && !o_frame_sync_out && !o_data_valid_out)
        else $error("timing outputs active while unpowered");
    chk_power_steady: assert property (
        $changed(o_panel_power) |=> $stable(o_panel_power) [*8])
        else $error("power toggled inside guard time");
    chk_apb_answer: assert property (
        i_psel && !i_penable |=> o_pready)
        else $error("no zero wait answer");
    chk_apb_err_pair: assert property (
        o_pslverr |-> o_pready && i_psel && i_penable)
        else $error("slave error outside access");
    cover property ($rose(o_panel_power));
    cover property ($fell(o_data_valid_out));
    cover property (o_pslverr);
endmodule

// >>> bench/lcd_panel_model.sv
// Behavioural LCD panel that measures the frame structure it receives
`timescale 1ns/10ps
module lcd_panel_model #(
    parameter DATA_W = 24
) (
    input  wire              i_clk,
    input  wire              i_rst,
    input  wire              i_valid,
    input  wire              i_line,
    input  wire              i_frame,
    input  wire              i_pclk,
    input  wire [DATA_W-1:0] i_data,
    output reg  [31:0]       o_clock_rises,
    output reg  [31:0]       o_frame_cycles,
    output reg  [31:0]       o_frame_high,
    output reg  [31:0]       o_lines,
    output reg  [31:0]       o_active_lines,
    output reg  [DATA_W-1:0] o_last_pixel
);
    reg [31:0] cyc, high, lines, act, rises;
    reg        prev_f, prev_l, prev_v, prev_c;

    // Counts core cycles: only lengths, not pixel clock phase, are judged
    always @(posedge i_clk) begin
        prev_f <= i_frame;
        prev_l <= i_line;
        prev_v <= i_valid;
        prev_c <= i_pclk;
        if (i_valid)
            o_last_pixel <= i_data;
        if (i_rst) begin
            {cyc, high, lines, act} <= 128'h0;
            {o_frame_cycles, o_frame_high, o_lines, o_active_lines} <= 128'h0;
            rises         <= 32'h0;
            o_clock_rises <= 32'h0;
        end else if (i_frame && !prev_f) begin
            // Pixel clock is idle at a frame start in gated mode
            o_clock_rises  <= rises;
            rises          <= 32'h0;
            o_frame_cycles <= cyc;
            o_frame_high   <= high;
            o_lines        <= lines;
            o_active_lines <= act;
            {cyc, high, lines, act} <= {32'h1, 32'h1, 64'h0};
        end else begin
            cyc   <= cyc + 32'h1;
            high  <= high + {31'h0, i_frame};
            lines <= lines + {31'h0, i_line && !prev_l};
            act   <= act + {31'h0, i_valid && !prev_v};
            rises <= rises + {31'h0, i_pclk && !prev_c};
        end
    end
endmodule

// >>> bench/lcd_panel_timing_test.sv
// Self-checking bench for the LCD panel timing block
`timescale 1ns/10ps
`include "lcd_timing_consts.vh"
module lcd_panel_timing_test;
    localparam int LINE = 15; // Pixel periods per line: phases 2+3+2+5+3
    logic        i_ref_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_psel = 1'b0;
    logic        i_penable = 1'b0;
    logic        i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h00000000;
    logic [23:0] i_pixel_data = 24'hA5C3F0;
    wire  [31:0] o_prdata, f_cyc, f_high, f_lines, f_act, f_clk;
    wire  [23:0] o_pixel_data_bus, last_px;
    wire         o_pready, o_pslverr, o_pixel_clock_out, o_data_valid_out;
    wire         o_line_sync_out, o_frame_sync_out, o_panel_power, o_contrast_out;
    wire  [3:0]  mon = {o_panel_power, o_frame_sync_out, o_line_sync_out, o_data_valid_out};
    logic [31:0] pctl [6] = '{32'hC, 32'hD, 32'hE, 32'hF, 32'h8, 32'hC};
    logic [31:0] pcmp [6] = '{32'h40, 32'h40, 32'h40, 32'h40, 32'hFF, 32'h0};
    int          phigh [6] = '{64, 128, 256, 512, 1, 0};
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          n_cycles = 0;

    // Core clock, 4 ns period
    always #2 i_ref_clk = ~i_ref_clk;

    // Whole-run limit, so a hang after the long power-up wait still ends as a failure
    always @(posedge i_ref_clk) begin
        n_cycles <= n_cycles + 1;
        if (n_cycles == 95000) begin
            n_mismatch++;
            stop_test();
        end
    end

    lcd_panel_timing #(.DATA_W(24)) dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_pixel_data(i_pixel_data), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_pixel_clock_out(o_pixel_clock_out),
        .o_data_valid_out(o_data_valid_out), .o_line_sync_out(o_line_sync_out),
        .o_frame_sync_out(o_frame_sync_out), .o_pixel_data_bus(o_pixel_data_bus),
        .o_panel_power(o_panel_power), .o_contrast_out(o_contrast_out));
    lcd_panel_model #(.DATA_W(24)) panel (
        .i_clk(i_ref_clk), .i_rst(i_rst), .i_valid(o_data_valid_out),
        .i_line(o_line_sync_out), .i_frame(o_frame_sync_out), .i_data(o_pixel_data_bus),
        .i_pclk(o_pixel_clock_out), .o_clock_rises(f_clk),
        .o_frame_cycles(f_cyc), .o_frame_high(f_high), .o_lines(f_lines),
        .o_active_lines(f_act), .o_last_pixel(last_px));

    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_compared++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("BAD at %0t seen %h expected %h", $time, seen, expd);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int k;
        k = 0;
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            k++;
        end while (o_pready !== 1'b1 && k < 64);
        if (k >= 64) begin
            n_mismatch++;
            stop_test();
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h00000000, r, e);
        check(r, x);
        check({31'h0, e}, {31'h0, xe});
    endtask

    // Counts edges until a monitored output reaches a level; bounded
    task automatic wait_lvl(input int sel, input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (mon[sel] !== lvl && n < 80000);
        if (n >= 80000) begin
            n_mismatch++;
            stop_test();
        end
    endtask

    initial begin
        logic [31:0] r;
        logic [31:0] r2;
        logic        e;
        int          n;
        repeat (12) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        rd_chk(`OFS_PANEL_POWER, `PP_RESET, 1'b0);
        rd_chk(`OFS_CONTRAST_CTRL, `CC_RESET, 1'b0);
        rd_chk(`OFS_CONTRAST_CMP, `CMP_RESET, 1'b0);
        wr(12'h020, 32'hFFFFFFFF);
        rd_chk(12'h020, 32'h00000000, 1'b1);
        // TFT, divider bypassed, so one pixel period is one core cycle
        wr(`OFS_FIRST_CTRL, 32'h00001000);
        wr(`OFS_SECOND_CTRL, 32'h00008002);
        wr(`OFS_VERT_TIMING, 32'h01000101);
        wr(`OFS_HORIZ_TIMING, 32'h00210201);
        rd_chk(`OFS_HORIZ_TIMING, 32'h00210201, 1'b0);
        wr(`OFS_FRAME_SIZE, 32'h00800002);
        wr(`OFS_PANEL_POWER, 32'h00000003);
        check({31'h0, o_panel_power}, 32'h0);
        wait_lvl(3, 1'b1, n);
        repeat (3) begin
            wait_lvl(2, 1'b0, n);
            wait_lvl(2, 1'b1, n);
        end
        @(posedge i_ref_clk);
        check(f_cyc, LINE * 5);
        check(f_high, LINE * 2);
        check(f_lines, 5);
        check(f_act, 3);
        // Horizontal phases of an active line and the next one
        wait_lvl(0, 1'b1, n);
        wait_lvl(0, 1'b0, n);
        check(n, 5);
        wait_lvl(1, 1'b1, n);
        check(n, 5);
        wait_lvl(1, 1'b0, n);
        check(n, 3);
        wait_lvl(0, 1'b1, n);
        check(n, 2);
        check({8'h00, last_px}, 32'h00A5C3F0);
        wr(`OFS_SECOND_CTRL, 32'h00008102);
        wait_lvl(0, 1'b0, n);
        wait_lvl(0, 1'b1, n);
        wait_lvl(0, 1'b0, n);
        @(posedge i_ref_clk);
        check({8'h00, last_px}, 32'h005A3C0F);
        wr(`OFS_SECOND_CTRL, 32'h00008002);
        // Line counter across the first two lines of a frame
        wait_lvl(2, 1'b0, n);
        wait_lvl(2, 1'b1, n);
        wait_lvl(1, 1'b1, n);
        wait_lvl(1, 1'b0, n);
        apb(1'b0, `OFS_FIRST_CTRL, 32'h0, r, e);
        wait_lvl(1, 1'b1, n);
        wait_lvl(1, 1'b0, n);
        apb(1'b0, `OFS_FIRST_CTRL, 32'h0, r2, e);
        check({21'h0, r2[31:21]}, {21'h0, r[31:21] - 11'h001});
        // STN with divider 2: four core cycles a pixel, no vertical porches
        wr(`OFS_FIRST_CTRL, 32'h00000002);
        wr(`OFS_VERT_TIMING, 32'h01000100);
        wr(`OFS_HORIZ_TIMING, 32'h00200201);
        wr(`OFS_SECOND_CTRL, 32'h00000000);
        repeat (3) begin
            wait_lvl(2, 1'b0, n);
            wait_lvl(2, 1'b1, n);
        end
        @(posedge i_ref_clk);
        check(f_cyc, LINE * 12);
        check(f_high, LINE * 4);
        check(f_act, 3);
        check(f_clk, 15); // Gated clock: five pixels on each of three lines
        wr(`OFS_PANEL_POWER, 32'h00000002);
        wait_lvl(3, 1'b0, n);
        check({31'h0, n <= LINE * 24}, 32'h1);
        // Contrast: each prescale rate, then both ends of the compare range
        for (int i = 0; i < 6; i++) begin
            wr(`OFS_CONTRAST_CMP, pcmp[i]);
            wr(`OFS_CONTRAST_CTRL, pctl[i]);
            repeat (16) @(posedge i_ref_clk);
            n = 0;
            repeat (256 << pctl[i][1:0]) begin
                @(posedge i_ref_clk);
                n += (o_contrast_out === 1'b1);
            end
            check(n, phigh[i]);
        end
        stop_test();
    end
endmodule

bind lcd_panel_timing lcd_panel_timing_assertions u_chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_data_valid_out(o_data_valid_out),
    .o_line_sync_out(o_line_sync_out), .o_frame_sync_out(o_frame_sync_out),
    .o_panel_power(o_panel_power));
